// ---- hdl/pwc_wakeup_counter.v ----
// Periodic wakeup counter: prescaler, 8-bit match counter, registers and interrupt.
`timescale 1ns/100ps
`include "pwc_regs.vh"

module pwc_wakeup_counter (
    input wire mclk,
    input wire resetn,
    input wire [`PWC_ADDR_W-1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStrobe,
    input wire regRdStrobe,
    output reg [7:0] regRdData,
    input wire lowPowerOscTick,
    input wire externalRefTick,
    input wire internalRefTick,
    input wire debugHalt,
    output wire irq
);

    reg matchFlag_r;
    reg matchFlag_nxt;
    reg [1:0] sourceSelect_r;
    reg matchIrqEnable_r;
    reg [3:0] dividerSelect_r;
    reg [7:0] liveCount_r;
    reg [7:0] liveCount_nxt;
    reg [7:0] matchLimit_r;
    reg [`PWC_PRE_W-1:0] prescale_r;
    reg [`PWC_PRE_W-1:0] prescale_nxt;
    reg srcLevel_r;
    reg [1:0] evtStatus_r;
    reg [1:0] evtStatus_nxt;
    reg [1:0] evtMask_r;
    reg [7:0] readMux;
    reg srcLevel;
    reg prePulse;
    reg matchEvent;
    reg restart;

    wire wrCtrl = regWrStrobe && (regAddr == `PWC_OFF_STATUS_CTRL);
    wire wrLimit = regWrStrobe && (regAddr == `PWC_OFF_MATCH_LIMIT);
    wire rdEvt = regRdStrobe && (regAddr == `PWC_OFF_EVT_STATUS);
    wire [1:0] wrSrc = regWrData[`PWC_SRC_HI:`PWC_SRC_LO];
    wire [3:0] wrDiv = regWrData[`PWC_DIV_HI:`PWC_DIV_LO];
    wire [`PWC_PRE_W-1:0] ratio;

    // Divide ratio for the current source bit 0 and divider select; zero means off.
    function [`PWC_PRE_W-1:0] divRatio;
        input srcBit;
        input [3:0] div;
        begin
            case ({srcBit, div})
                5'h00: divRatio = 18'h00000;
                5'h01: divRatio = 18'h00008;
                5'h02: divRatio = 18'h00020;
                5'h03: divRatio = 18'h00040;
                5'h04: divRatio = 18'h00080;
                5'h05: divRatio = 18'h00100;
                5'h06: divRatio = 18'h00200;
                5'h07: divRatio = 18'h00400;
                5'h08: divRatio = 18'h00001;
                5'h09: divRatio = 18'h00002;
                5'h0a: divRatio = 18'h00004;
                5'h0b: divRatio = 18'h0000a;
                5'h0c: divRatio = 18'h00010;
                5'h0d: divRatio = 18'h00064;
                5'h0e: divRatio = 18'h001f4;
                5'h0f: divRatio = 18'h003e8;
                5'h10: divRatio = 18'h00000;
                5'h11: divRatio = 18'h00400;
                5'h12: divRatio = 18'h00800;
                5'h13: divRatio = 18'h01000;
                5'h14: divRatio = 18'h02000;
                5'h15: divRatio = 18'h04000;
                5'h16: divRatio = 18'h08000;
                5'h17: divRatio = 18'h10000;
                5'h18: divRatio = 18'h003e8;
                5'h19: divRatio = 18'h007d0;
                5'h1a: divRatio = 18'h01388;
                5'h1b: divRatio = 18'h02710;
                5'h1c: divRatio = 18'h04e20;
                5'h1d: divRatio = 18'h0c350;
                5'h1e: divRatio = 18'h186a0;
                5'h1f: divRatio = 18'h30d40;
                default: divRatio = 18'h00000;
            endcase
        end
    endfunction

    assign ratio = divRatio(sourceSelect_r[0], dividerSelect_r);

    always @* begin
        // The high source bit wins so both 1x codes pick the internal clock.
        if (sourceSelect_r[1]) begin
            srcLevel = internalRefTick;
        end else if (sourceSelect_r[0]) begin
            srcLevel = externalRefTick;
        end else begin
            srcLevel = lowPowerOscTick;
        end
    end

    always @* begin
        restart = wrLimit
            || (wrCtrl && (wrSrc != sourceSelect_r))
            || (wrCtrl && (wrDiv != dividerSelect_r));
        prePulse = 1'b0;
        matchEvent = 1'b0;
        prescale_nxt = prescale_r;
        liveCount_nxt = liveCount_r;
        if (restart) begin
            prescale_nxt = {`PWC_PRE_W{1'b0}};
            liveCount_nxt = `PWC_RST_BYTE;
        end else if (!debugHalt && (ratio != {`PWC_PRE_W{1'b0}})
                     && srcLevel && !srcLevel_r) begin
            if (prescale_r == ratio - 18'h00001) begin
                prescale_nxt = {`PWC_PRE_W{1'b0}};
                prePulse = 1'b1;
            end else begin
                prescale_nxt = prescale_r + 18'h00001;
            end
        end
        if (prePulse) begin
            if (liveCount_r == matchLimit_r) begin
                // A limit of zero keeps the count at zero and flags every pulse.
                liveCount_nxt = `PWC_RST_BYTE;
                matchEvent = 1'b1;
            end else begin
                liveCount_nxt = liveCount_r + 8'h01;
            end
        end
        // A match in the cycle of a clearing write keeps the flag set.
        matchFlag_nxt = matchEvent
            || (matchFlag_r && !(wrCtrl && regWrData[`PWC_FLAG_BIT]));
        evtStatus_nxt = (rdEvt ? 2'h0 : evtStatus_r) | {restart, matchEvent};
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            matchFlag_r <= 1'b0;
            sourceSelect_r <= `PWC_SRC_LPO;
            matchIrqEnable_r <= 1'b0;
            dividerSelect_r <= 4'h0;
            matchLimit_r <= `PWC_RST_BYTE;
            liveCount_r <= `PWC_RST_BYTE;
            prescale_r <= {`PWC_PRE_W{1'b0}};
            srcLevel_r <= 1'b0;
            evtStatus_r <= `PWC_RST_EVT;
            evtMask_r <= `PWC_RST_EVT;
        end else begin
            matchFlag_r <= matchFlag_nxt;
            liveCount_r <= liveCount_nxt;
            prescale_r <= prescale_nxt;
            srcLevel_r <= srcLevel;
            evtStatus_r <= evtStatus_nxt;
            if (wrCtrl) begin
                sourceSelect_r <= wrSrc;
                matchIrqEnable_r <= regWrData[`PWC_IE_BIT];
                dividerSelect_r <= wrDiv;
            end
            if (wrLimit) begin
                matchLimit_r <= regWrData;
            end
            if (regWrStrobe && (regAddr == `PWC_OFF_EVT_MASK)) begin
                evtMask_r <= regWrData[1:0];
            end
        end
    end

    always @* begin
        case (regAddr)
            `PWC_OFF_STATUS_CTRL:
                readMux = {matchFlag_r, sourceSelect_r, matchIrqEnable_r, dividerSelect_r};
            `PWC_OFF_LIVE_COUNT: readMux = liveCount_r;
            `PWC_OFF_MATCH_LIMIT: readMux = matchLimit_r;
            `PWC_OFF_EVT_STATUS: readMux = {6'h00, evtStatus_r};
            `PWC_OFF_EVT_MASK: readMux = {6'h00, evtMask_r};
            default: readMux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe and return to zero otherwise.
    always @(posedge mclk) begin
        if (!resetn) begin
            regRdData <= 8'h00;
        end else if (regRdStrobe) begin
            regRdData <= readMux;
        end else begin
            regRdData <= 8'h00;
        end
    end

    assign irq = (matchFlag_r && matchIrqEnable_r)
        || ((evtStatus_r & evtMask_r) != 2'h0);

endmodule // pwc_wakeup_counter

// ---- hdl/pwc_regs.vh ----
// Register map, field positions, reset values and prescaler width of the wakeup counter.
`ifndef PWC_REGS_VH
`define PWC_REGS_VH

`define PWC_ADDR_W 3
`define PWC_OFF_STATUS_CTRL 3'h0
`define PWC_OFF_LIVE_COUNT 3'h1
`define PWC_OFF_MATCH_LIMIT 3'h2
`define PWC_OFF_EVT_STATUS 3'h3
`define PWC_OFF_EVT_MASK 3'h4

`define PWC_FLAG_BIT 7
`define PWC_SRC_HI 6
`define PWC_SRC_LO 5
`define PWC_IE_BIT 4
`define PWC_DIV_HI 3
`define PWC_DIV_LO 0

`define PWC_SRC_LPO 2'h0
`define PWC_SRC_EXT 2'h1

`define PWC_EVT_MATCH 0
`define PWC_EVT_RESTART 1

`define PWC_RST_BYTE 8'h00
`define PWC_RST_EVT 2'h0
`define PWC_PRE_W 18

`endif

// ---- verification/pwc_wakeup_counter_chk.sv ----
// Port-level assertions of the periodic wakeup counter.
`timescale 1ns/100ps
module pwc_wakeup_counter_chk (
    input wire mclk,
    input wire resetn,
    input wire [2:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStrobe,
    input wire regRdStrobe,
    input wire [7:0] regRdData,
    input wire lowPowerOscTick,
    input wire externalRefTick,
    input wire internalRefTick,
    input wire debugHalt,
    input wire irq
);
    reg [2:0] tickHist_r;
    // A raised request needs a recent source level or a register write as its cause.
    always @(posedge mclk) tickHist_r <= {tickHist_r[1:0],
        lowPowerOscTick | externalRefTick | internalRefTick};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence sLimWr; regWrStrobe && regAddr == 3'h2; endsequence
    sequence sCtlWr; regWrStrobe && regAddr == 3'h0; endsequence
    a_read_idle_zero: assert property (!regRdStrobe |=> regRdData == 8'h00)
        else $error("read data not zero when idle");
    a_reset_irq_low: assert property ($rose(resetn) |-> !irq)
        else $error("irq high after reset");
    a_irq_rise_cause: assert property ($rose(irq) |-> $past(regWrStrobe) || |tickHist_r)
        else $error("irq rose without cause");
    a_halt_holds_irq: assert property (debugHalt && $past(debugHalt) && $past(debugHalt, 2)
        && !$past(regWrStrobe) |-> !$rose(irq))
        else $error("irq rose while halted");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(regWrStrobe) || $past(regRdStrobe))
        else $error("irq fell without access");
    a_limit_readback: assert property (sLimWr ##1 (regRdStrobe && regAddr == 3'h2)
        |=> regRdData == $past(regWrData, 2))
        else $error("limit readback wrong");
    a_count_cleared: assert property (sLimWr ##1 (regRdStrobe && regAddr == 3'h1)
        |=> regRdData == 8'h00)
        else $error("count not cleared by limit write");
    a_ctrl_readback: assert property (sCtlWr ##1 (regRdStrobe && regAddr == 3'h0)
        |=> {1'h0, regRdData[6:0]} == ($past(regWrData, 2) & 8'h7f))
        else $error("control readback wrong");
endmodule // pwc_wakeup_counter_chk

bind pwc_wakeup_counter pwc_wakeup_counter_chk u_chk (.mclk(mclk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .lowPowerOscTick(lowPowerOscTick),
    .externalRefTick(externalRefTick), .internalRefTick(internalRefTick),
    .debugHalt(debugHalt), .irq(irq));

// ---- verification/pwc_wakeup_counter_test.sv ----
// Self-checking bench of the periodic wakeup counter.
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module pwc_wakeup_counter_test;
    logic mclk = 0;
    logic resetn = 0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrStrobe = 0;
    logic regRdStrobe = 0;
    logic [7:0] regRdData;
    logic [2:0] tick = 3'h0;
    logic debugHalt = 0;
    logic irq;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int k;
    int dv[7] = '{8, 9, 10, 11, 12, 1, 2};
    int rt[7] = '{1, 2, 4, 10, 16, 8, 32};
    pwc_wakeup_counter u_dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
        .regRdData(regRdData), .lowPowerOscTick(tick[0]), .externalRefTick(tick[1]),
        .internalRefTick(tick[2]), .debugHalt(debugHalt), .irq(irq));
    always #2 mclk = ~mclk;
    task end_of_test;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_fail++;
            end_of_test;
        end
    end
    // Tasks end one step after the edge so a following call never drives a strobe twice.
    task wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'h1;
        @(posedge mclk);
        regWrStrobe <= 1'h0;
        #1;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        regAddr <= a;
        regRdStrobe <= 1'h1;
        @(posedge mclk);
        regRdStrobe <= 1'h0;
        #1;
        `CHK(regRdData, e)
    endtask
    task edges(input int s, input int n);
        repeat (n) begin
            tick[s] <= 1'h1;
            @(posedge mclk);
            tick[s] <= 1'h0;
            @(posedge mclk);
        end
        #1;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'h1;
        @(posedge mclk);
        #1;
        for (k = 0; k < 6; k++) rd(k[2:0], 8'h00);
        wr(3'h2, 8'ha5);
        rd(3'h2, 8'ha5);
        wr(3'h1, 8'h55);
        rd(3'h1, 8'h00);
        wr(3'h2, 8'h02);
        wr(3'h0, 8'h18);
        edges(0, 2);
        rd(3'h1, 8'h02);
        `CHK(irq, 1'h0)
        edges(0, 1);
        rd(3'h1, 8'h00);
        rd(3'h0, 8'h98);
        `CHK(irq, 1'h1)
        wr(3'h0, 8'h18);
        rd(3'h0, 8'h98);
        wr(3'h0, 8'h98);
        rd(3'h0, 8'h18);
        `CHK(irq, 1'h0)
        wr(3'h2, 8'h00);
        edges(0, 1);
        rd(3'h0, 8'h98);
        wr(3'h2, 8'hff);
        for (k = 0; k < 7; k++) begin
            wr(3'h0, dv[k][7:0]);
            edges(0, 2 * rt[k] - 1);
            rd(3'h1, 8'h01);
        end
        wr(3'h0, 8'h02);
        rd(3'h1, 8'h01);
        wr(3'h0, 8'h28);
        rd(3'h1, 8'h00);
        edges(0, 5);
        edges(1, 999);
        rd(3'h1, 8'h00);
        edges(1, 1);
        rd(3'h1, 8'h01);
        wr(3'h0, 8'h48);
        edges(1, 3);
        edges(2, 1);
        rd(3'h1, 8'h01);
        debugHalt <= 1'h1;
        edges(2, 4);
        rd(3'h1, 8'h01);
        debugHalt <= 1'h0;
        edges(2, 1);
        rd(3'h1, 8'h02);
        wr(3'h0, 8'h68);
        rd(3'h1, 8'h00);
        edges(1, 2);
        edges(2, 1000);
        rd(3'h1, 8'h01);
        wr(3'h0, 8'h40);
        edges(2, 3);
        rd(3'h1, 8'h00);
        rd(3'h3, 8'h03);
        rd(3'h3, 8'h00);
        wr(3'h4, 8'h02);
        wr(3'h2, 8'h10);
        rd(3'h1, 8'h00);
        `CHK(irq, 1'h1)
        rd(3'h3, 8'h02);
        `CHK(irq, 1'h0)
        end_of_test;
    end
endmodule // pwc_wakeup_counter_test
